// ===== core/irq_idle_ctrl.sv
// interrupt arbitration, nesting and idle-mode control
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module irq_idle_ctrl
   import irq_pkg::*;
(
   input  wire logic              clk_sys,               // oscillator clock
   input  wire logic              rst_n,                 // sync reset, active low
   input  wire logic [ADDR_W-1:0] reg_addr,              // register address
   input  wire logic [DATA_W-1:0] reg_wdata,             // write data
   input  wire logic              reg_wr,                // write strobe
   input  wire logic              reg_rd,                // read strobe
   output logic      [DATA_W-1:0] reg_rdata,             // read data, next cycle
   input  wire logic              ext_irq_a,             // external pin request a
   input  wire logic              ext_irq_b,             // external pin request b
   input  wire logic              timer0_req,            // timer 0 overflow
   input  wire logic              timer1_req,            // timer 1 overflow
   input  wire logic              timer2_req,            // timer 2 overflow
   input  wire logic              serial_req,            // serial port request
   input  wire logic              insn_boundary,         // core may take a vector now
   input  wire logic              return_from_interrupt, // core ends a service
   output logic                   irq_take,              // vector issued, pulse
   output logic      [VEC_W-1:0]  irq_vector,            // issued source index
   output logic      [LVL_W-1:0]  irq_level,             // issued level
   output logic                   cpu_clk_en,            // cpu clock gate
   input  wire logic              cpu_ale,               // core address latch strobe
   input  wire logic              cpu_program_store_strobe,              // core program store strobe
   output logic                   ale_out,               // address latch strobe pin
   output logic                   program_store_strobe,  // program store strobe pin
   output logic                   irq_out                // event interrupt, level
);
   // overview
   // six request lines are gated by their own enable and by the global
   // enable, then the picker chooses the highest level, lowest index
   // among equals. a four-bit in-service mask remembers which levels are
   // open; a vector is only issued when the winner is strictly above the
   // highest open level, so nesting depth is bounded by the level count.
   // the core says when an instruction ends; while the idle bit is set
   // the core clock is gated off, so the block samples every cycle
   // instead and a qualifying request both ends idle and issues at once.
   // limitation: the external pins are taken as active-high levels that
   // are already conditioned; edge detection belongs upstream.
   // trade-off: the pins cost two cycles of synchroniser latency, so a
   // pin and a timer raised together are not simultaneous here and the
   // timer may win although polling order puts the pin first.
   // hazard: a return and a take in one cycle are resolved on the state
   // before the return; the retired level and the new one never clash
   // because the new one must be above the retired one.
   logic [1:0]       ext_s;                  // synchronised pins
   logic [N_SRC-1:0] req;                    // raw request vector
   logic [N_SRC-1:0] req_en;                 // requests passing enables
   logic [7:0]       en_q, en_d;             // enable register
   logic [5:0]       plo_q, plo_d;           // priority low bits
   logic [5:0]       phi_q, phi_d;           // priority high bits
   logic [3:0]       pwr_q, pwr_d;           // power control register
   logic [2:0]       stat_q, stat_d;         // event status
   logic [2:0]       mask_q, mask_d;         // event mask
   logic [N_LVL-1:0] svc_q, svc_d;           // levels in service
   logic             take_q, take_d;         // issue pulse
   logic [VEC_W-1:0] vec_q, vec_d;           // issued vector
   logic [LVL_W-1:0] lvl_q, lvl_d;           // issued level
   logic [DATA_W-1:0] rd_q, rd_d;            // read data
   logic             best_v;                 // a request is pending
   logic [VEC_W-1:0] best_i;                 // pending winner
   logic [LVL_W-1:0] best_l;                 // winner level
   logic [LVL_W-1:0] cur_l;                  // highest level in service
   logic             busy;                   // something in service
   logic             wake;                   // enabled request seen in idle
   logic             idle_q;                 // idle bit alias
   logic [N_LVL-1:0] svc_tmp;                // service after return

   // pins come from outside the clock domain
   // timers and serial come from this clock and skip the synchroniser
   pin_sync #(.W(2)) u_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .pin_in  ({ext_irq_b, ext_irq_a}),
      .pin_out (ext_s)
   );

   // source vector in polling order
   always_comb begin
      req            = '0;
      req[SRC_EXT_A] = ext_s[0];
      req[SRC_TMR0]  = timer0_req;
      req[SRC_EXT_B] = ext_s[1];
      req[SRC_TMR1]  = timer1_req;
      req[SRC_SER]   = serial_req;
      req[SRC_TMR2]  = timer2_req;
      req_en = req & en_q[N_SRC-1:0] & {N_SRC{en_q[EN_GLOBAL_BIT]}};
   end

   // the picker is pure logic; its result is registered on the take path
   prio_pick u_pick (
      .req    (req_en),
      .lvl_lo (plo_q),
      .lvl_hi (phi_q),
      .valid  (best_v),
      .idx    (best_i),
      .lvl    (best_l)
   );

   // current service level is the highest bit set
   // at most one bit per level, so the top set bit is the open level
   always_comb begin
      cur_l   = '0;
      busy    = |svc_q;
      for (int l = 0; l < N_LVL; l++) begin
         if (svc_q[l]) begin
            cur_l = LVL_W'(l);
         end
      end
   end

   assign idle_q = pwr_q[PWR_IDLE_BIT];
   // only a request that may be served ends idle, so a woken core gets a vector
   assign wake   = idle_q && best_v && (!busy || best_l > cur_l);

   // register file, idle control and nesting: next values
   always_comb begin
      en_d   = en_q;
      plo_d  = plo_q;
      phi_d  = phi_q;
      pwr_d  = pwr_q;
      mask_d = mask_q;
      stat_d = stat_q;
      rd_d   = '0;
      take_d = 1'b0;
      vec_d  = vec_q;
      lvl_d  = lvl_q;
      // software writes
      if (reg_wr) begin
         unique case (reg_addr)
            REG_ENABLE:   en_d  = reg_wdata;
            REG_PRIO_LO:  plo_d = reg_wdata[5:0];
            REG_PRIO_HI:  phi_d = reg_wdata[5:0];
            REG_POWER:    pwr_d = reg_wdata[3:0];
            REG_EVT_STAT: stat_d = stat_q & ~reg_wdata[2:0];
            REG_EVT_MASK: mask_d = reg_wdata[2:0];
            default:      ;                                             // unmapped: ignored
         endcase
      end
      // wake clears idle and powerdown, flags kept as they are
      if (wake) begin
         pwr_d[PWR_IDLE_BIT] = 1'b0;
         pwr_d[PWR_PD_BIT]   = 1'b0;
         stat_d[EVT_WAKE]    = 1'b1;
      end
      // return retires the highest active level
      // a stray return is flagged rather than silently dropped
      svc_tmp = svc_q;
      if (return_from_interrupt) begin
         if (busy) begin
            svc_tmp[cur_l] = 1'b0;
         end else begin
            stat_d[EVT_RET_ERR] = 1'b1;
         end
      end
      svc_d = svc_tmp;
      // sample at a boundary, or at once when idle halted the core
      // the comparison uses the mask before this cycle's return
      if ((insn_boundary || idle_q) && best_v && (!busy || best_l > cur_l)) begin
         take_d          = 1'b1;
         vec_d           = best_i;
         lvl_d           = best_l;
         svc_d[best_l]   = 1'b1;
         stat_d[EVT_TAKE] = 1'b1;                                       // set wins over clear
      end
      // reads show the block's own state
      // read data are zero in every cycle without a read strobe
      if (reg_rd) begin
         unique case (reg_addr)
            REG_ENABLE:   rd_d = en_q;
            REG_PRIO_LO:  rd_d = {2'h0, plo_q};
            REG_PRIO_HI:  rd_d = {2'h0, phi_q};
            REG_POWER:    rd_d = {4'h0, pwr_q};
            REG_EVT_STAT: rd_d = {5'h00, stat_q};
            REG_EVT_MASK: rd_d = {5'h00, mask_q};
            default:      rd_d = '0;
         endcase
      end
   end

   // register stage; reset also ends idle at once
   // one register stage for the control state; outputs other than the strobes come from these flops
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         en_q   <= ENABLE_RST;
         plo_q  <= PRIO_RST;
         phi_q  <= PRIO_RST;
         pwr_q  <= POWER_RST;
         stat_q <= EVT_RST;
         mask_q <= EVT_RST;
         svc_q  <= '0;
         take_q <= 1'b0;
         vec_q  <= '0;
         lvl_q  <= '0;
         rd_q   <= '0;
      end else begin
         en_q   <= en_d;
         plo_q  <= plo_d;
         phi_q  <= phi_d;
         pwr_q  <= pwr_d;
         stat_q <= stat_d;
         mask_q <= mask_d;
         svc_q  <= svc_d;
         take_q <= take_d;
         vec_q  <= vec_d;
         lvl_q  <= lvl_d;
         rd_q   <= rd_d;
      end
   end

   // outputs; freezing the core clock holds its registers and pins
   // strobes are forced high so external memory sees no cycle in idle
   // the interrupt line follows the registers with no extra delay
   always_comb begin
      reg_rdata            = rd_q;
      irq_take             = take_q;
      irq_vector           = vec_q;
      irq_level            = lvl_q;
      cpu_clk_en           = !idle_q;
      ale_out              = idle_q ? 1'b1 : cpu_ale;
      program_store_strobe = idle_q ? 1'b1 : cpu_program_store_strobe;
      irq_out              = |(stat_q & mask_q);
   end

   // assertions and the history that they need
   logic [5:0] plo_p, phi_p;                 // priority low/high one cycle back
   logic [7:0] en_p;                         // enable one cycle back
   logic [1:0] cur_p;                        // open level one cycle back
   logic       busy_p;                       // busy one cycle back
   logic       rd_p;                         // read strobe one cycle back
   logic       seen_rst_q;                   // reset was seen earlier
   // history flops, not reset: they only feed checks
   always_ff @(posedge clk_sys) begin
      plo_p      <= plo_q;
      phi_p      <= phi_q;
      en_p       <= en_q;
      cur_p      <= cur_l;
      busy_p     <= busy;
      rd_p       <= reg_rd;
      seen_rst_q <= !rst_n;
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   // a vector needs its own enable in the deciding cycle
   AST_EN_GATE: assert property (irq_take |-> en_p[irq_vector])
      else $error("source taken while its enable was clear");
   // global enable off blocks every source
   AST_GLOBAL_GATE: assert property ($past(!en_q[EN_GLOBAL_BIT]) |-> !irq_take)
      else $error("source taken while global enable was clear");
   // issued level equals the two priority bits of the winner
   AST_LEVEL_ENC: assert property (irq_take |->
         irq_level == {phi_p[irq_vector], plo_p[irq_vector]})
      else $error("issued level does not match priority bits");
   // nesting only goes strictly upward
   AST_PREEMPT: assert property (irq_take && busy_p |-> irq_level > cur_p)
      else $error("preemption by a level not strictly higher");
   // an idle write from the running state gates the core clock next cycle
   AST_IDLE_ENTER: assert property (
         reg_wr && reg_addr == REG_POWER && reg_wdata[PWR_IDLE_BIT] && !idle_q
         |=> idle_q && !cpu_clk_en)
      else $error("idle write did not stop the core clock");
   // both strobes high and the core clock off throughout idle
   AST_IDLE_PINS: assert property (idle_q |->
         ale_out && program_store_strobe && !cpu_clk_en)
      else $error("strobes or clock gate wrong during idle");
   // outside idle the strobes pass straight through
   AST_STRB_RUN: assert property (!idle_q |->
         ale_out == cpu_ale && program_store_strobe == cpu_program_store_strobe)
      else $error("strobes not passed through while running");
   // a servable request ends idle and issues in the next cycle
   AST_WAKE: assert property (idle_q && wake |=>
         !idle_q && irq_take && cpu_clk_en)
      else $error("enabled request did not end idle and issue a vector");
   // an interrupt exit clears powerdown along with idle
   AST_PD_CLEAR: assert property (idle_q && pwr_q[PWR_PD_BIT] && wake
         |=> !pwr_q[PWR_PD_BIT] && !idle_q)
      else $error("powerdown bit survived an interrupt exit");
   // an idle exit by hardware never touches the user flags
   AST_FLAGS: assert property ($changed(idle_q) && !$past(reg_wr)
         |-> $stable(pwr_q[PWR_FLAG_B:PWR_FLAG_A]))
      else $error("user flags changed on idle transition");
   // the cycle after any reset edge the core runs again
   AST_RESET_IDLE: assert property (disable iff (1'b0)
         seen_rst_q |-> !idle_q && cpu_clk_en)
      else $error("reset did not end idle");
   // read data stand only in the cycle after a read strobe
   AST_RD_ZERO: assert property (!rd_p |-> reg_rdata == '0)
      else $error("read data not zero outside the read answer");
   // every issued vector is recorded as an event
   AST_EVT_TAKE: assert property (irq_take |-> stat_q[EVT_TAKE])
      else $error("vector issued without its event bit");

   COV_TAKE:    cover property (irq_take);
   COV_IDLE_IN: cover property (reg_wr && reg_addr == REG_POWER && reg_wdata[PWR_IDLE_BIT]);
   COV_WAKE:    cover property (idle_q && wake ##1 irq_take);
   COV_PREEMPT: cover property (busy_p && irq_take);
   COV_PD_WAKE: cover property (idle_q && pwr_q[PWR_PD_BIT] && wake);
endmodule : irq_idle_ctrl

// ===== core/irq_pkg.sv
// constants for interrupt arbitration and idle control
// Operation
// - six sources, each with own vector
// - per-source enable blocks disabled sources
// - global enable clear blocks every source
// - level is high bit over low bit
// - preempt only by strictly higher level
// - simultaneous different levels: higher served first
// - idle bit write enters idle after instruction
// - idle stops cpu clock, peripherals run
// - idle preserves cpu state and pins
// - idle drives both strobes high
// - enabled interrupt clears idle and is served (here only one above the highest open service level)
// - after return, resume after idle instruction
// - two user flags untouched by idle
// - reset ends idle within two machine cycles
// - idle plus powerdown: interrupt clears both bits
package irq_pkg;
   localparam int          N_SRC     = 6;      // request sources
   localparam int          N_LVL     = 4;      // priority levels
   localparam int          LVL_W     = 2;      // level width
   localparam int          VEC_W     = 3;      // vector index width
   localparam int          ADDR_W    = 4;      // register address width
   localparam int          DATA_W    = 8;      // register data width
   localparam int          N_EVT     = 3;      // event status bits
   // source index doubles as polling order
   localparam int          SRC_EXT_A = 0;
   localparam int          SRC_TMR0  = 1;
   localparam int          SRC_EXT_B = 2;
   localparam int          SRC_TMR1  = 3;
   localparam int          SRC_SER   = 4;
   localparam int          SRC_TMR2  = 5;
   // register offsets
   localparam logic [3:0]  REG_ENABLE    = 4'h0;
   localparam logic [3:0]  REG_PRIO_LO   = 4'h1;
   localparam logic [3:0]  REG_PRIO_HI   = 4'h2;
   localparam logic [3:0]  REG_POWER     = 4'h3;
   localparam logic [3:0]  REG_EVT_STAT  = 4'h4;
   localparam logic [3:0]  REG_EVT_MASK  = 4'h5;
   // field positions
   localparam int          EN_GLOBAL_BIT = 7;
   localparam int          PWR_IDLE_BIT  = 0;
   localparam int          PWR_PD_BIT    = 1;
   localparam int          PWR_FLAG_A    = 2;
   localparam int          PWR_FLAG_B    = 3;
   localparam int          EVT_TAKE      = 0;
   localparam int          EVT_WAKE      = 1;
   localparam int          EVT_RET_ERR   = 2;
   // reset values
   localparam logic [7:0]  ENABLE_RST    = 8'h00;
   localparam logic [5:0]  PRIO_RST      = 6'h00;
   localparam logic [3:0]  POWER_RST     = 4'h0;
   localparam logic [2:0]  EVT_RST       = 3'h0;
   // timing: clk_sys is the oscillator
   localparam int          CLK_PERIOD_NS   = 10;
   localparam int          OSC_PER_MCYC    = 12;
   localparam int          RESET_HOLD_MCYC = 2;
   localparam int          RESET_HOLD_CYC  = RESET_HOLD_MCYC * OSC_PER_MCYC;
endpackage : irq_pkg

// ===== core/pin_sync.sv
// two-stage synchroniser for asynchronous request pins
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 2                  // number of pins
) (
   input  wire logic         clk_sys,   // system clock
   input  wire logic         rst_n,     // sync reset, active low
   input  wire logic [W-1:0] pin_in,    // raw pin levels
   output logic      [W-1:0] pin_out    // synchronised levels
);
   logic [W-1:0] meta_q;                // first stage, read only by second
   // one pair of flops per pin
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_sys) begin
         if (!rst_n) begin
            meta_q[i]  <= 1'b0;
            pin_out[i] <= 1'b0;
         end else begin
            meta_q[i]  <= pin_in[i];
            pin_out[i] <= meta_q[i];
         end
      end
   end
endmodule : pin_sync

// ===== core/prio_pick.sv
// picks the highest-level request, lowest index among equals
`timescale 1ns/1ps
module prio_pick
   import irq_pkg::*;
(
   input  wire logic [N_SRC-1:0] req,     // enabled requests
   input  wire logic [N_SRC-1:0] lvl_lo,  // low level bits
   input  wire logic [N_SRC-1:0] lvl_hi,  // high level bits
   output logic                  valid,   // any request
   output logic      [VEC_W-1:0] idx,     // winning source
   output logic      [LVL_W-1:0] lvl      // winning level
);
   // scan downward so that lower index wins ties
   always_comb begin
      valid = 1'b0;
      idx   = '0;
      lvl   = '0;
      for (int i = N_SRC - 1; i >= 0; i--) begin
         if (req[i] && (!valid || {lvl_hi[i], lvl_lo[i]} >= lvl)) begin
            valid = 1'b1;
            idx   = VEC_W'(i);
            lvl   = {lvl_hi[i], lvl_lo[i]};
         end
      end
   end
endmodule : prio_pick

// ===== bench/core_model.sv
// behavioural processor core: boundaries, strobes and service returns
`timescale 1ns/1ps
module core_model (
   input  wire logic clk_sys,               // oscillator clock
   input  wire logic rst_n,                 // sync reset, active low
   input  wire logic cpu_clk_en,            // gated core clock
   input  wire logic irq_take,              // vector issued
   input  wire logic ret_go,                // bench asks for a return
   output logic      insn_boundary,         // vector may be taken
   output logic      return_from_interrupt, // end of service pulse
   output logic      cpu_ale,               // address latch strobe
   output logic      cpu_program_store_strobe               // program store strobe
);
   logic [2:0] depth_q; // services still open

   // every cycle ends an instruction while the core clock runs
   assign insn_boundary = cpu_clk_en;
   // strobes alternate, so a stopped core leaves one of them low
   assign cpu_program_store_strobe = ~cpu_ale;

   // strobe toggling and service bookkeeping
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cpu_ale               <= 1'h0;
         depth_q               <= 3'h0;
         return_from_interrupt <= 1'h0;
      end else begin
         // a stopped core clock freezes the strobes
         if (cpu_clk_en) begin
            cpu_ale <= ~cpu_ale;
         end
         // a return only closes a service that was opened
         return_from_interrupt <= ret_go && (depth_q != 3'h0);
         depth_q <= depth_q + {2'h0, irq_take} - {2'h0, return_from_interrupt};
      end
   end
endmodule : core_model

// ===== bench/interrupt_priority_idle_control_test.sv
// self-checking bench for interrupt arbitration and idle control
`timescale 1ns/1ps
module interrupt_priority_idle_control_test;
   import irq_pkg::*;
   typedef struct packed {
      logic [5:0] req;  // requests by source index
      logic [7:0] en;   // enable register
      logic [5:0] lo;   // priority low bits
      logic [5:0] hi;   // priority high bits
      logic       take; // vector expected
      logic [2:0] vec;  // expected source
      logic [1:0] lvl;  // expected level
   } row_t;
   logic              clk_sys   = 1'h0; // oscillator
   logic              rst_n     = 1'h0; // reset, active low
   logic [ADDR_W-1:0] reg_addr  = 4'h0; // register address
   logic [DATA_W-1:0] reg_wdata = 8'h0; // write data
   logic              reg_wr    = 1'h0; // write strobe
   logic              reg_rd    = 1'h0; // read strobe
   logic [5:0]        req       = 6'h0; // request levels
   logic              ret_go    = 1'h0; // return command to core
   logic [DATA_W-1:0] reg_rdata;        // read data
   logic              insn_boundary, return_from_interrupt, cpu_ale, cpu_program_store_strobe;
   logic              irq_take, cpu_clk_en, ale_out, program_store_strobe, irq_out;
   logic [VEC_W-1:0]  irq_vector;       // issued source
   logic [LVL_W-1:0]  irq_level;        // issued level
   int                err_count = 0;    // mismatches
   int                compares  = 0;    // comparisons made
   row_t              rows [12];        // ordinary cases

   always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;

   irq_idle_ctrl dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .ext_irq_a(req[0]), .timer0_req(req[1]), .ext_irq_b(req[2]), .timer1_req(req[3]),
      .serial_req(req[4]), .timer2_req(req[5]), .insn_boundary(insn_boundary),
      .return_from_interrupt(return_from_interrupt), .irq_take(irq_take),
      .irq_vector(irq_vector), .irq_level(irq_level), .cpu_clk_en(cpu_clk_en),
      .cpu_ale(cpu_ale), .cpu_program_store_strobe(cpu_program_store_strobe), .ale_out(ale_out),
      .program_store_strobe(program_store_strobe), .irq_out(irq_out));
   core_model core_u (.clk_sys(clk_sys), .rst_n(rst_n), .cpu_clk_en(cpu_clk_en),
      .irq_take(irq_take), .ret_go(ret_go), .insn_boundary(insn_boundary),
      .return_from_interrupt(return_from_interrupt), .cpu_ale(cpu_ale), .cpu_program_store_strobe(cpu_program_store_strobe));

   // one comparison, reported at once on a mismatch
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr    <= 1'h1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'h0;
   endtask : reg_write

   // read data stand only in the cycle after the read edge
   task automatic reg_check(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      reg_rd   <= 1'h1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'h0;
      #1;
      check(reg_rdata, exp);
   endtask : reg_check

   // waits a bounded span for a vector, allowing for pin synchroniser delay
   task automatic expect_take(input logic t, input logic [2:0] v, input logic [1:0] l);
      #1;
      for (int n = 0; n < 8 && irq_take !== 1'h1; n++) begin
         @(posedge clk_sys);
         #1;
      end
      check({7'h0, irq_take}, {7'h0, t});
      if (t) begin
         check({5'h0, irq_vector}, {5'h0, v});
         check({6'h0, irq_level}, {6'h0, l});
      end
   endtask : expect_take

   task automatic service_end();
      @(posedge clk_sys);
      ret_go <= 1'h1;
      @(posedge clk_sys);
      ret_go <= 1'h0;
      repeat (3) @(posedge clk_sys);
   endtask : service_end

   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : print_verdict

   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #100000;
      err_count++;
      print_verdict();
   end

   initial begin
      rows = '{'{6'h01, 8'h81, 6'h00, 6'h00, 1'h1, 3'h0, 2'h0},
               '{6'h02, 8'h82, 6'h02, 6'h00, 1'h1, 3'h1, 2'h1},
               '{6'h04, 8'h84, 6'h00, 6'h04, 1'h1, 3'h2, 2'h2},
               '{6'h08, 8'h88, 6'h08, 6'h08, 1'h1, 3'h3, 2'h3},
               '{6'h10, 8'h90, 6'h00, 6'h00, 1'h1, 3'h4, 2'h0},
               '{6'h20, 8'hA0, 6'h00, 6'h00, 1'h1, 3'h5, 2'h0},
               '{6'h3F, 8'h3F, 6'h00, 6'h00, 1'h0, 3'h0, 2'h0},
               '{6'h3F, 8'h80, 6'h00, 6'h00, 1'h0, 3'h0, 2'h0},
               '{6'h05, 8'hBF, 6'h00, 6'h00, 1'h1, 3'h0, 2'h0},
               '{6'h3F, 8'hBE, 6'h00, 6'h00, 1'h1, 3'h1, 2'h0},
               '{6'h21, 8'hA1, 6'h00, 6'h20, 1'h1, 3'h5, 2'h2},
               '{6'h30, 8'hB0, 6'h10, 6'h20, 1'h1, 3'h5, 2'h2}};
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'h1;
      // ordinary cases: enables, levels and polling order
      foreach (rows[i]) begin
         reg_write(REG_PRIO_LO, {2'h0, rows[i].lo});
         reg_write(REG_PRIO_HI, {2'h0, rows[i].hi});
         reg_write(REG_ENABLE, rows[i].en);
         @(posedge clk_sys);
         req <= rows[i].req;
         expect_take(rows[i].take, rows[i].vec, rows[i].lvl);
         @(posedge clk_sys);
         req <= 6'h00;
         repeat (3) @(posedge clk_sys);
         if (rows[i].take) begin
            service_end();
         end
      end
      // nesting: lower waits, higher preempts, top level never preempted
      reg_write(REG_PRIO_LO, 8'h1A);
      reg_write(REG_PRIO_HI, 8'h18);
      reg_write(REG_ENABLE, 8'hBF);
      @(posedge clk_sys);
      req <= 6'h02;
      expect_take(1'h1, 3'h1, 2'h1);
      @(posedge clk_sys);
      req <= 6'h03;
      expect_take(1'h0, 3'h0, 2'h0);
      @(posedge clk_sys);
      req <= 6'h13;
      expect_take(1'h1, 3'h4, 2'h3);
      @(posedge clk_sys);
      req <= 6'h1B;
      expect_take(1'h0, 3'h0, 2'h0);
      @(posedge clk_sys);
      req <= 6'h00;
      repeat (3) @(posedge clk_sys);
      service_end();
      service_end();
      // idle with powerdown and both user flags, woken by the serial source
      reg_write(REG_ENABLE, 8'h90);
      reg_write(REG_POWER, 8'h0F);
      repeat (3) begin
         @(posedge clk_sys);
         #1;
         check({5'h0, cpu_clk_en, ale_out, program_store_strobe}, 8'h03);
      end
      @(posedge clk_sys);
      req <= 6'h10;
      expect_take(1'h1, 3'h4, 2'h3);
      check({7'h0, cpu_clk_en}, 8'h01);
      check({6'h0, ale_out, program_store_strobe}, {6'h0, cpu_ale, cpu_program_store_strobe});
      @(posedge clk_sys);
      req <= 6'h00;
      reg_check(REG_POWER, 8'h0C);
      service_end();
      // events: sticky status, mask, write-one clear, unmapped place
      reg_check(REG_EVT_STAT, 8'h03);
      check({7'h0, irq_out}, 8'h00);
      reg_write(REG_EVT_MASK, 8'h02);
      @(posedge clk_sys);
      #1;
      check({7'h0, irq_out}, 8'h01);
      reg_write(REG_EVT_STAT, 8'h02);
      reg_write(4'hF, 8'hFF);
      @(posedge clk_sys);
      #1;
      check({7'h0, irq_out}, 8'h00);
      reg_check(REG_EVT_STAT, 8'h01);
      reg_check(4'hF, 8'h00);
      // reset during idle, held for two machine cycles
      reg_write(REG_POWER, 8'h01);
      @(posedge clk_sys);
      rst_n <= 1'h0;
      repeat (RESET_HOLD_CYC) @(posedge clk_sys);
      rst_n <= 1'h1;
      #1;
      check({7'h0, cpu_clk_en}, 8'h01);
      for (int a = 0; a < 6; a++) begin
         reg_check(4'(a), 8'h00);
      end
      print_verdict();
   end
endmodule : interrupt_priority_idle_control_test
